// >>> rtl/xb_consts.svh
`ifndef XB_CONSTS_SVH
`define XB_CONSTS_SVH

// Register addresses
`define XB_ADDR_DP0_LOW 8'h82
`define XB_ADDR_DP0_HIGH 8'h83
`define XB_ADDR_DP1_LOW 8'h84
`define XB_ADDR_DP1_HIGH 8'h85
`define XB_ADDR_PTR_SEL 8'h86
`define XB_ADDR_EXTERNAL_DATA_MOVE_PAGE 8'h92
`define XB_ADDR_AP1_HIGH 8'h9a
`define XB_ADDR_AP1_LOW 8'h9b
`define XB_ADDR_AP2_HIGH 8'h9d
`define XB_ADDR_AP2_LOW 8'h9e
`define XB_ADDR_PORT_DATA 8'ha0
`define XB_ADDR_PORT_OE 8'hb4

// Reset values and fields
`define XB_RST_BYTE 8'h00
`define XB_RST_ADDR 16'h0000
`define XB_PTR_SEL_BIT 0

// Input clock period, then clock output periods at 48, 24 and 12 MHz, in picoseconds
`define XB_CLK_PS 8000
`define XB_TCL48_PS 20830
`define XB_TCL24_PS 41660
`define XB_TCL12_PS 83200
`define XB_CYC(ps) (((ps) + `XB_CLK_PS - 1) / `XB_CLK_PS)

// Bus cycle lengths in clock output cycles
`define XB_FETCH_TICKS 5'h03
`define XB_DATA_TICKS 5'h03
`define XB_STRETCH_STEP 5'h02
`define XB_PWR_WAIT_TICKS 5'h02
`define XB_PRD_WAIT_TICKS 5'h03
`define XB_PSTB_TICKS 5'h02

`endif

// >>> rtl/xb_pkg.sv
package xb_pkg;

   typedef enum logic [2:0] {
      XB_IDLE = 3'b000,
      XB_FETCH = 3'b001,
      XB_DREAD = 3'b010,
      XB_DWRITE = 3'b011,
      XB_PWAIT = 3'b100,
      XB_PSTROBE = 3'b101
   } xb_state_t;

   typedef enum logic [1:0] {
      XB_KIND_FETCH = 2'b00,
      XB_KIND_READ = 2'b01,
      XB_KIND_WRITE = 2'b10
   } xb_kind_t;

   typedef enum logic [2:0] {
      XB_SRC_PC = 3'b000,
      XB_SRC_DPTR = 3'b001,
      XB_SRC_INDEX = 3'b010,
      XB_SRC_AP1 = 3'b011,
      XB_SRC_AP2 = 3'b100
   } xb_src_t;

   typedef struct packed {
      xb_kind_t kind;
      xb_src_t src;
      logic [15:0] pc;
      logic [7:0] index_low;
      logic [7:0] wdata;
   } xb_req_t;

   typedef enum logic [1:0] {
      XB_SPEED_12 = 2'b00,
      XB_SPEED_24 = 2'b01,
      XB_SPEED_48 = 2'b10
   } xb_speed_t;

endpackage

// >>> rtl/xb_clkdiv.sv
`timescale 1ns/1ps
`include "xb_consts.svh"

module xb_clkdiv #(
   parameter logic [3:0] DIV48 = 4'(`XB_CYC(`XB_TCL48_PS)),
   parameter logic [3:0] DIV24 = 4'(`XB_CYC(`XB_TCL24_PS)),
   parameter logic [3:0] DIV12 = 4'(`XB_CYC(`XB_TCL12_PS))
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire xb_pkg::xb_speed_t i_speed,
   output logic o_tick,
   output logic o_cpu_clock_output
);
   import xb_pkg::*;

   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [3:0] div;
   logic clk_reg;

   assign div = (i_speed == XB_SPEED_48) ? DIV48 :
                (i_speed == XB_SPEED_24) ? DIV24 : DIV12; // R08
   assign o_tick = (cnt_reg >= div - 4'h1);
   assign cnt_next = o_tick ? 4'h0 : cnt_reg + 4'h1;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cnt_reg <= 4'h0;
         clk_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         clk_reg <= (cnt_next < (div >> 1)); // R08
      end
   end

   assign o_cpu_clock_output = clk_reg;

endmodule // xb_clkdiv

// >>> rtl/xb_ext_bus.sv
// Summary of operation
// R01 - With strobe option on, port reads pulse read and writes pulse write; the code strobes only for accesses made while the bus is idle.
// R02 - Strobe option follows the enable bit; when clear, no port strobes.
// R03 - Each port strobe pulse lasts exactly two clock output cycles.
// R04 - Port write: update value, wait two cycles, write strobe two cycles.
// R05 - First auto pointer address appears only while a strobe is low.
// R06 - Second auto pointer address holds for the whole bus cycle.
// R07 - Stretch lengthens data accesses only; fetches keep fixed timing.
// R08 - Clock output runs at 12, 24 or 48 MHz; bus timing scales.
// R09 - Index register moves take address bits 15..8 from the page register.
// R10 - Bit 0 of pointer select picks data pointer; reset picks pointer 0.
// R11 - Fetches drive program strobe low then high with address, OE, CS.
// R12 - Peripheral treats port read strobe as prefetch cue only.
// R13 - Read and write strobes are active low and idle high.
`timescale 1ns/1ps
`include "xb_consts.svh"

module xb_ext_bus (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire xb_pkg::xb_speed_t i_speed,
   input wire logic [2:0] i_stretch,
   input wire logic i_io_port_strobe_enable,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   input wire logic i_xreq_valid,
   input wire xb_pkg::xb_req_t i_xreq,
   output logic o_xreq_ready,
   output logic o_xdone,
   output logic [7:0] o_xrdata,
   output logic o_cpu_clock_output,
   output logic [15:0] o_addr,
   output logic [7:0] o_data_out,
   output logic o_data_oe_n,
   input wire logic [7:0] i_data_in,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic o_program_store_strobe_n,
   output logic o_mem_oe_n,
   output logic o_cs_n,
   output logic [7:0] o_third_io_port_out,
   output logic [7:0] o_third_io_port_oe_n,
   input wire logic [7:0] i_third_io_port_in
);
   import xb_pkg::*;

   function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] b);
      sfr_hit = (a == b);
   endfunction

   logic tick;
   logic [7:0] dp0l_reg, dp0h_reg, dp1l_reg, dp1h_reg, psel_reg;
   logic [7:0] external_data_move_upper_page_reg, ap1h_reg, ap1l_reg, ap2h_reg, ap2l_reg;
   logic [7:0] port_reg, port_oe_reg, rdata_reg, rdata_next;
   xb_state_t state_reg, state_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [4:0] data_len;
   logic prd_reg, prd_next;
   xb_src_t src_reg;
   logic [15:0] addr_reg, addr_next;
   logic [7:0] wdata_reg, xrdata_reg;
   logic done_reg;
   logic idle, last, port_wr, port_rd, port_trig, take;
   logic [4:0] ph_ticks_reg;

   xb_clkdiv u_div (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_speed(i_speed),
      .o_tick(tick),
      .o_cpu_clock_output(o_cpu_clock_output)
   );

   // Register writes and reads
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         dp0l_reg <= `XB_RST_BYTE;
         dp0h_reg <= `XB_RST_BYTE;
         dp1l_reg <= `XB_RST_BYTE;
         dp1h_reg <= `XB_RST_BYTE;
         psel_reg <= `XB_RST_BYTE; // R10
         external_data_move_upper_page_reg <= `XB_RST_BYTE;
         ap1h_reg <= `XB_RST_BYTE;
         ap1l_reg <= `XB_RST_BYTE;
         ap2h_reg <= `XB_RST_BYTE;
         ap2l_reg <= `XB_RST_BYTE;
         port_reg <= `XB_RST_BYTE;
         port_oe_reg <= `XB_RST_BYTE;
         rdata_reg <= `XB_RST_BYTE;
      end else begin
         rdata_reg <= rdata_next;
         if (i_sfr_wr) begin
            case (i_sfr_addr)
               `XB_ADDR_DP0_LOW: dp0l_reg <= i_sfr_wdata;
               `XB_ADDR_DP0_HIGH: dp0h_reg <= i_sfr_wdata;
               `XB_ADDR_DP1_LOW: dp1l_reg <= i_sfr_wdata;
               `XB_ADDR_DP1_HIGH: dp1h_reg <= i_sfr_wdata;
               `XB_ADDR_PTR_SEL: psel_reg <=
                  {7'h00, i_sfr_wdata[`XB_PTR_SEL_BIT]}; // R10
               `XB_ADDR_EXTERNAL_DATA_MOVE_PAGE: external_data_move_upper_page_reg <= i_sfr_wdata;
               `XB_ADDR_AP1_HIGH: ap1h_reg <= i_sfr_wdata;
               `XB_ADDR_AP1_LOW: ap1l_reg <= i_sfr_wdata;
               `XB_ADDR_AP2_HIGH: ap2h_reg <= i_sfr_wdata;
               `XB_ADDR_AP2_LOW: ap2l_reg <= i_sfr_wdata;
               `XB_ADDR_PORT_DATA: port_reg <= i_sfr_wdata; // R04
               `XB_ADDR_PORT_OE: port_oe_reg <= i_sfr_wdata;
               default: ;
            endcase
         end
      end
   end

   always_comb begin
      rdata_next = rdata_reg;
      if (i_sfr_rd) begin
         case (i_sfr_addr)
            `XB_ADDR_DP0_LOW: rdata_next = dp0l_reg;
            `XB_ADDR_DP0_HIGH: rdata_next = dp0h_reg;
            `XB_ADDR_DP1_LOW: rdata_next = dp1l_reg;
            `XB_ADDR_DP1_HIGH: rdata_next = dp1h_reg;
            `XB_ADDR_PTR_SEL: rdata_next = psel_reg;
            `XB_ADDR_EXTERNAL_DATA_MOVE_PAGE: rdata_next = external_data_move_upper_page_reg;
            `XB_ADDR_AP1_HIGH: rdata_next = ap1h_reg;
            `XB_ADDR_AP1_LOW: rdata_next = ap1l_reg;
            `XB_ADDR_AP2_HIGH: rdata_next = ap2h_reg;
            `XB_ADDR_AP2_LOW: rdata_next = ap2l_reg;
            `XB_ADDR_PORT_DATA: rdata_next = i_third_io_port_in;
            `XB_ADDR_PORT_OE: rdata_next = port_oe_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   assign o_sfr_rdata = rdata_reg;
   assign o_third_io_port_out = port_reg;
   assign o_third_io_port_oe_n = ~port_oe_reg;

   // Port access detection and request acceptance
   assign idle = (state_reg == XB_IDLE);
   assign port_wr = i_sfr_wr && sfr_hit(i_sfr_addr, `XB_ADDR_PORT_DATA);
   assign port_rd = i_sfr_rd && sfr_hit(i_sfr_addr, `XB_ADDR_PORT_DATA);
   assign port_trig = idle && i_io_port_strobe_enable
                      && (port_wr || port_rd); // R01 R02
   assign o_xreq_ready = idle && !port_trig;
   assign take = o_xreq_ready && i_xreq_valid;
   assign last = tick && (cnt_reg == 5'h00);
   assign data_len = `XB_DATA_TICKS
                     + 5'(i_stretch * `XB_STRETCH_STEP) - 5'h01; // R07

   // Address source selection
   always_comb begin
      case (i_xreq.src)
         XB_SRC_DPTR: addr_next = psel_reg[`XB_PTR_SEL_BIT] ?
            {dp1h_reg, dp1l_reg} : {dp0h_reg, dp0l_reg}; // R10
         XB_SRC_INDEX: addr_next = {external_data_move_upper_page_reg, i_xreq.index_low}; // R09
         XB_SRC_AP1: addr_next = {ap1h_reg, ap1l_reg};
         XB_SRC_AP2: addr_next = {ap2h_reg, ap2l_reg};
         default: addr_next = i_xreq.pc;
      endcase
   end

   // Cycle sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      prd_next = prd_reg;
      case (state_reg)
         XB_IDLE: begin
            if (port_trig) begin
               state_next = XB_PWAIT;
               prd_next = port_rd;
               cnt_next = (port_rd ? `XB_PRD_WAIT_TICKS
                           : `XB_PWR_WAIT_TICKS) - 5'h01; // R04
            end else if (take) begin
               case (i_xreq.kind)
                  XB_KIND_FETCH: begin
                     state_next = XB_FETCH;
                     cnt_next = `XB_FETCH_TICKS - 5'h01; // R07
                  end
                  XB_KIND_READ: begin
                     state_next = XB_DREAD;
                     cnt_next = data_len;
                  end
                  default: begin
                     state_next = XB_DWRITE;
                     cnt_next = data_len;
                  end
               endcase
            end
         end
         XB_PWAIT: begin
            if (last) begin
               state_next = XB_PSTROBE;
               cnt_next = `XB_PSTB_TICKS - 5'h01; // R03
            end else if (tick) begin
               cnt_next = cnt_reg - 5'h01;
            end
         end
         XB_FETCH, XB_DREAD, XB_DWRITE, XB_PSTROBE: begin
            if (last) begin
               state_next = XB_IDLE;
            end else if (tick) begin
               cnt_next = cnt_reg - 5'h01;
            end
         end
         default: state_next = XB_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_reg <= XB_IDLE;
         cnt_reg <= 5'h00;
         prd_reg <= 1'b0;
         src_reg <= XB_SRC_PC;
         addr_reg <= `XB_RST_ADDR;
         wdata_reg <= `XB_RST_BYTE;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         prd_reg <= prd_next;
         if (take) begin
            src_reg <= i_xreq.src;
            addr_reg <= addr_next;
            wdata_reg <= i_xreq.wdata;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         xrdata_reg <= `XB_RST_BYTE;
         done_reg <= 1'b0;
      end else begin
         done_reg <= last && (state_reg == XB_FETCH
                     || state_reg == XB_DREAD || state_reg == XB_DWRITE);
         if (last && (state_reg == XB_FETCH || state_reg == XB_DREAD)) begin
            xrdata_reg <= i_data_in;
         end
      end
   end

   assign o_xdone = done_reg;
   assign o_xrdata = xrdata_reg;

   // Pin drive
   assign o_rd_n = !(state_reg == XB_DREAD
                   || (state_reg == XB_PSTROBE && prd_reg)); // R01 R13
   assign o_wr_n = !(state_reg == XB_DWRITE
                   || (state_reg == XB_PSTROBE && !prd_reg)); // R01 R13
   assign o_program_store_strobe_n = (state_reg != XB_FETCH); // R11
   assign o_mem_oe_n = !(state_reg == XB_FETCH || state_reg == XB_DREAD);
   assign o_cs_n = !(state_reg == XB_FETCH || state_reg == XB_DREAD
                   || state_reg == XB_DWRITE); // R11
   assign o_addr = (src_reg == XB_SRC_AP1 && o_rd_n && o_wr_n) ?
                   `XB_RST_ADDR : addr_reg; // R05 R06
   assign o_data_out = wdata_reg;
   assign o_data_oe_n = (state_reg != XB_DWRITE);

   // Ticks seen in the current phase, for checking
   always_ff @(posedge i_clk) begin
      if (i_reset || state_next != state_reg) begin
         ph_ticks_reg <= 5'h00;
      end else if (tick) begin
         ph_ticks_reg <= ph_ticks_reg + 5'h01;
      end
   end

   AST_NO_STB_OFF: assert property (@(posedge i_clk) disable iff (i_reset)
      idle && (port_wr || port_rd) && !i_io_port_strobe_enable
      |=> state_reg != XB_PWAIT) // R02
      else $error("port strobe started while option off");
   AST_STB_START: assert property (@(posedge i_clk) disable iff (i_reset)
      idle && port_wr && i_io_port_strobe_enable
      |=> state_reg == XB_PWAIT && !prd_reg) // R01
      else $error("port write did not start a strobe");
   AST_STB_LEN: assert property (@(posedge i_clk) disable iff (i_reset)
      state_reg == XB_PSTROBE && last |-> ph_ticks_reg == 5'h01) // R03
      else $error("port strobe not two clock output cycles");
   AST_WR_WAIT: assert property (@(posedge i_clk) disable iff (i_reset)
      state_reg == XB_PWAIT && last && !prd_reg
      |-> ph_ticks_reg == 5'h01 ##1 !o_wr_n) // R04
      else $error("write strobe wait not two cycles");
   AST_AP1_GATE: assert property (@(posedge i_clk) disable iff (i_reset)
      src_reg == XB_SRC_AP1 && o_rd_n && o_wr_n
      |-> o_addr == 16'h0000) // R05
      else $error("first auto pointer address outside strobe");
   AST_AP2_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_reg == XB_DREAD || state_reg == XB_DWRITE)
      && src_reg == XB_SRC_AP2 |-> o_addr == {ap2h_reg, ap2l_reg}) // R06
      else $error("second auto pointer address not held");
   AST_FETCH_FIXED: assert property (@(posedge i_clk) disable iff (i_reset)
      state_reg == XB_FETCH && last |-> ph_ticks_reg == 5'h02) // R07
      else $error("fetch length changed");
   AST_IDLE_HIGH: assert property (@(posedge i_clk) disable iff (i_reset)
      idle |-> o_rd_n && o_wr_n && o_program_store_strobe_n) // R13
      else $error("strobe low while idle");
   AST_PAGE: assert property (@(posedge i_clk) disable iff (i_reset)
      take && i_xreq.src == XB_SRC_INDEX
      |=> o_addr[15:8] == $past(external_data_move_upper_page_reg)) // R09
      else $error("page byte not used for index move");
   AST_PSEL: assert property (@(posedge i_clk) disable iff (i_reset)
      take && i_xreq.src == XB_SRC_DPTR && !psel_reg[0]
      |=> o_addr == $past({dp0h_reg, dp0l_reg})) // R10
      else $error("pointer 0 not selected");
   AST_PROGRAM_STORE_STROBE_N: assert property (@(posedge i_clk) disable iff (i_reset)
      take && i_xreq.kind == XB_KIND_FETCH
      |=> !o_program_store_strobe_n && !o_cs_n && !o_mem_oe_n) // R11
      else $error("fetch strobes not asserted");

endmodule // xb_ext_bus

// >>> dv/xb_mem_model.sv
`timescale 1ns/1ps
module xb_mem_model (
   input wire logic i_clk,
   input wire logic [15:0] i_addr,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic i_program_store_strobe_n_n,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic [7:0] o_port,
   output logic [7:0] o_last_wr
);
   logic [7:0] last_reg = 8'h00;
   logic rd_reg = 1'b0;
   wire logic rd_on = !i_rd_n || !i_program_store_strobe_n_n;
   wire logic [7:0] val = i_addr[7:0] ^ i_addr[15:8] ^ 8'h5a;
   // Released bus shows the inverse of the last byte, never a held value
   assign o_rdata = rd_on ? val : ~last_reg;
   initial begin
      o_port = 8'h31;
      o_last_wr = 8'h00;
   end
   always @(posedge i_clk) begin
      rd_reg <= !i_rd_n;
      if (rd_on) begin
         last_reg <= val;
      end
      if (!i_wr_n) begin
         o_last_wr <= i_wdata;
      end
      // Next byte only after the read pulse ends
      if (rd_reg && i_rd_n) begin
         o_port <= o_port + 8'h01;
      end
   end
endmodule // xb_mem_model

// >>> dv/tb_cpu_external_bus_and_port_strobe.sv
`timescale 1ns/1ps
module tb_cpu_external_bus_and_port_strobe;
   import xb_pkg::*;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   xb_speed_t i_speed = XB_SPEED_48;
   logic [2:0] i_stretch = 3'h0;
   logic i_io_port_strobe_enable = 1'b0;
   logic [7:0] i_sfr_addr = 8'h00;
   logic i_sfr_wr = 1'b0;
   logic i_sfr_rd = 1'b0;
   logic [7:0] i_sfr_wdata = 8'h00;
   logic i_xreq_valid = 1'b0;
   xb_req_t i_xreq = '0;
   logic [7:0] o_sfr_rdata, o_xrdata, o_data_out, i_data_in, last_wr;
   logic [7:0] o_third_io_port_out, o_third_io_port_oe_n;
   logic [7:0] i_third_io_port_in;
   logic [15:0] o_addr;
   logic o_xreq_ready, o_xdone, o_rd_n, o_wr_n, o_program_store_strobe_n;
   logic clk_out, data_oe_n, mem_oe_n, cs_n;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [7:0] regs [10] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h92,
      8'h9a, 8'h9b, 8'h9d, 8'h9e};
   logic [7:0] vals [10] = '{8'h34, 8'h12, 8'hcd, 8'hab, 8'hff, 8'h5e,
      8'h71, 8'h22, 8'h63, 8'h44};
   xb_speed_t spd [3] = '{XB_SPEED_48, XB_SPEED_24, XB_SPEED_12};
   int dv [3] = '{3, 6, 11};

   always #4 i_clk = ~i_clk;

   xb_ext_bus u_xb_ext_bus (
      .i_clk, .i_reset, .i_speed, .i_stretch, .i_io_port_strobe_enable,
      .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata,
      .i_xreq_valid, .i_xreq, .o_xreq_ready, .o_xdone, .o_xrdata,
      .o_cpu_clock_output(clk_out), .o_addr, .o_data_out,
      .o_data_oe_n(data_oe_n), .i_data_in, .o_rd_n, .o_wr_n,
      .o_program_store_strobe_n, .o_mem_oe_n(mem_oe_n), .o_cs_n(cs_n),
      .o_third_io_port_out,
      .o_third_io_port_oe_n, .i_third_io_port_in
   );

   xb_mem_model u_xb_mem_model (
      .i_clk(i_clk), .i_addr(o_addr), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
      .i_program_store_strobe_n_n(o_program_store_strobe_n), .i_wdata(o_data_out),
      .o_rdata(i_data_in), .o_port(i_third_io_port_in),
      .o_last_wr(last_wr)
   );

   task automatic finish_test();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   task automatic sfr(input logic wr, input logic [7:0] a, d);
      @(posedge i_clk);
      i_sfr_wr <= wr;
      i_sfr_rd <= !wr;
      i_sfr_addr <= a;
      i_sfr_wdata <= d;
      @(posedge i_clk);
      i_sfr_wr <= 1'b0;
      i_sfr_rd <= 1'b0;
      @(negedge i_clk);
   endtask

   task automatic t_regs();
      for (int i = 0; i < 10; i++) begin
         sfr(1'b0, regs[i], 8'h00);
         chk(o_sfr_rdata === 8'h00, "register reset value");
         sfr(1'b1, regs[i], vals[i]);
         sfr(1'b0, regs[i], 8'h00);
         chk(o_sfr_rdata === (i == 4 ? 8'h01 : vals[i]), "readback");
      end
      sfr(1'b1, 8'h93, 8'h77);
      sfr(1'b0, 8'h93, 8'h00);
      chk(o_sfr_rdata === 8'h00, "unmapped read");
      sfr(1'b1, 8'hb4, 8'h0f);
      chk(o_third_io_port_oe_n === 8'hf0, "port output enable");
   endtask

   task automatic t_port(input int div, input logic wr);
      logic [7:0] pin;
      int w;
      int n;
      pin = i_third_io_port_in;
      sfr(wr, 8'ha0, 8'h5c);
      if (wr) begin
         chk(o_third_io_port_out === 8'h5c, "port value first");
      end else begin
         chk(o_sfr_rdata === pin, "port read value");
      end
      for (w = 0; (wr ? o_wr_n : o_rd_n) && w < 200; w++) @(negedge i_clk);
      for (n = 0; !(wr ? o_wr_n : o_rd_n) && n < 200; n++) @(negedge i_clk);
      chk(w >= (wr ? 1 : 2) * div && w <= (wr ? 2 : 3) * div + 1,
         "strobe delay");
      chk(n == 2 * div, "strobe width");
   endtask

   task automatic t_clk(input int div);
      int n;
      for (n = 0; clk_out !== 1'b0 && n < 50; n++) @(negedge i_clk);
      for (n = 0; clk_out !== 1'b1 && n < 50; n++) @(negedge i_clk);
      for (n = 0; clk_out === 1'b1 && n < 50; n++) @(negedge i_clk);
      for (; clk_out === 1'b0 && n < 50; n++) @(negedge i_clk);
      chk(n == div, "clock output period");
   endtask

   task automatic t_rst();
      @(posedge i_clk);
      i_reset <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_reset <= 1'b0;
      @(negedge i_clk);
      chk(o_rd_n && o_wr_n && o_program_store_strobe_n && cs_n
         && o_xreq_ready && !o_xdone, "idle after reset");
      chk(o_third_io_port_oe_n === 8'hff, "port enable reset");
      sfr(1'b0, 8'h86, 8'h00);
      chk(o_sfr_rdata === 8'h00, "pointer select reset");
   endtask

   task automatic t_off(input logic wr);
      int n;
      sfr(wr, 8'ha0, 8'ha5);
      for (n = 0; n < 100 && o_wr_n && o_rd_n; n++) @(negedge i_clk);
      chk(n == 100, "strobe while disabled");
   endtask

   task automatic t_ext(input xb_kind_t k, input xb_src_t s,
         input logic [15:0] ea, input int t, input logic [2:0] st);
      int n;
      int c;
      logic [15:0] a;
      logic same;
      logic low;
      logic ctl;
      for (n = 0; !o_xreq_ready && n < 100; n++) @(negedge i_clk);
      @(posedge i_clk);
      i_stretch <= st;
      i_xreq_valid <= 1'b1;
      i_xreq <= '{k, s, 16'h3c21, 8'h44, ea[15:8]};
      @(posedge i_clk);
      i_xreq_valid <= 1'b0;
      n = 0;
      same = 1'b1;
      ctl = 1'b1;
      a = 16'h0000;
      for (c = 0; o_xdone !== 1'b1 && c < 300; c++) begin
         @(negedge i_clk);
         low = k == XB_KIND_FETCH ? !o_program_store_strobe_n :
            (k == XB_KIND_READ ? !o_rd_n : !o_wr_n);
         if (low) begin
            n++;
            a = n == 1 ? o_addr : a;
            same = same && o_addr === a;
            ctl = ctl && cs_n === 1'b0 && (k == XB_KIND_WRITE ?
               data_oe_n === 1'b0 : mem_oe_n === 1'b0 && data_oe_n === 1'b1);
         end
      end
      chk(n > (t - 1) * 3 && n <= t * 3, "cycle length");
      chk(a === ea && same, "bus address");
      chk(ctl, "bus control strobes");
      if (k == XB_KIND_WRITE) begin
         chk(last_wr === ea[15:8], "write data");
      end else begin
         chk(o_xrdata === (ea[7:0] ^ ea[15:8] ^ 8'h5a), "read data");
      end
      if (s == XB_SRC_AP1) begin
         chk(o_addr === 16'h0000, "pointer one address hidden");
      end
   endtask

   initial begin
      repeat (3) @(posedge i_clk);
      i_reset <= 1'b0;
      t_regs();
      @(posedge i_clk);
      i_io_port_strobe_enable <= 1'b1;
      for (int j = 0; j < 3; j++) begin
         @(posedge i_clk);
         i_speed <= spd[j];
         repeat (30) @(negedge i_clk);
         t_port(dv[j], 1'b1);
         t_port(dv[j], 1'b0);
         t_clk(dv[j]);
      end
      @(posedge i_clk);
      i_speed <= XB_SPEED_48;
      i_io_port_strobe_enable <= 1'b0;
      t_off(1'b1);
      t_off(1'b0);
      sfr(1'b1, 8'h86, 8'h00);
      t_ext(XB_KIND_FETCH, XB_SRC_PC, 16'h3c21, 3, 3'h3);
      t_ext(XB_KIND_READ, XB_SRC_DPTR, 16'h1234, 3, 3'h0);
      sfr(1'b1, 8'h86, 8'h01);
      t_ext(XB_KIND_READ, XB_SRC_DPTR, 16'habcd, 5, 3'h1);
      t_ext(XB_KIND_WRITE, XB_SRC_INDEX, 16'h5e44, 3, 3'h0);
      t_ext(XB_KIND_READ, XB_SRC_AP1, 16'h7122, 5, 3'h1);
      t_ext(XB_KIND_WRITE, XB_SRC_AP2, 16'h6344, 7, 3'h2);
      t_rst();
      finish_test();
   end
endmodule // tb_cpu_external_bus_and_port_strobe
